// ===== usw_pkg.sv
package usw_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int DR_W   = 8;
  localparam int CNT_W  = 4;
  localparam int SYNC_N = 3;
  localparam int WM_W   = 2;

  // ****************************************
  // Field positions and codes
  // ****************************************
  localparam int DR_MSB  = 7;
  localparam int DR_LSB  = 0;
  localparam int SY_NEW  = 0;
  localparam int SY_MID  = 1;
  localparam int SY_OLD  = 2;

  localparam logic [WM_W-1:0]  WM_THREE_WIRE = 2'h1;
  localparam logic [CNT_W-1:0] CNT_MAX       = 4'hf;
  localparam logic [1:0]       INC_NONE      = 2'h0;
  localparam logic [1:0]       INC_ONE       = 2'h1;
  localparam logic [1:0]       INC_TWO       = 2'h2;

  // Control readback layout
  localparam int RD_WM_HI   = 5;
  localparam int RD_WM_LO   = 4;
  localparam int RD_ECS     = 3;
  localparam int RD_CES     = 2;
  localparam int RD_STROBE  = 1;
  localparam int RD_TOGGLE  = 0;
  localparam int RD_W       = 8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [DR_W-1:0]  DR_RST  = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
  localparam logic [WM_W-1:0]  WM_RST  = 2'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [WM_W-1:0] wire_mode;
    logic            external_clock_select;
    logic            clock_edge_select;
    logic            clock_strobe_sel;
  } usw_ctl_t;

  localparam usw_ctl_t CTL_RST = '{WM_RST, 1'b0, 1'b0, 1'b0};

endpackage

// ===== usw_link_if.sv
`timescale 1ns/1ps
interface usw_link_if;
  logic rise_tgl;
  logic fall_tgl;
  logic rise_bit;
  logic fall_bit;

  modport link_end (
    output rise_tgl,
    output fall_tgl,
    output rise_bit,
    output fall_bit
  );

  modport core_end (
    input rise_tgl,
    input fall_tgl,
    input rise_bit,
    input fall_bit
  );
endinterface

// ===== usw_link_edge.sv
`timescale 1ns/1ps
module usw_link_edge
  import usw_pkg::*;
(
  input  wire logic    link_sck,
  input  wire logic    rst,
  input  wire logic    serial_data_in,
  usw_link_if.link_end lk
);

  // ****************************************
  // State per serial clock edge
  // ****************************************
  typedef struct packed {
    logic tgl;
    logic bit_q;
  } usw_edge_st_t;

  usw_edge_st_t rise_r;
  usw_edge_st_t rise_nxt;
  usw_edge_st_t fall_r;
  usw_edge_st_t fall_nxt;

  // Each edge captures the data pin and flips its event toggle
  always_comb begin
    rise_nxt       = rise_r;
    fall_nxt       = fall_r;
    rise_nxt.tgl   = ~rise_r.tgl;
    rise_nxt.bit_q = serial_data_in;
    fall_nxt.tgl   = ~fall_r.tgl;
    fall_nxt.bit_q = serial_data_in;
    if (rst) begin
      rise_nxt = '0;
      fall_nxt = '0;
    end
  end

  always_ff @(posedge link_sck) begin
    rise_r <= rise_nxt;
  end

  always_ff @(negedge link_sck) begin
    fall_r <= fall_nxt;
  end

  assign lk.rise_tgl = rise_r.tgl;
  assign lk.rise_bit = rise_r.bit_q;
  assign lk.fall_tgl = fall_r.tgl;
  assign lk.fall_bit = fall_r.bit_q;

endmodule

// ===== usw_three_wire.sv
`timescale 1ns/1ps
// Functional notes
// - Toggle strobe write inverts clock port bit.
// - Toggle ignores direction; direction gates pin.
// - Toggle strobe bit always reads zero.
// - External clock, strobe select: toggle clocks counter.
// - SPI modes 0/1, no slave select.
// - Eight clocks exchange both shift registers.
// - Serial clock advances counter; overflow sets flag.
// - Mode 0 samples rising, shifts falling.
// - Mode 1 samples falling, shifts rising.
// - Counter counts both edges, sixteen per byte.
// - Data set up half cycle before sampling.
// - Data write sets output; direction enables driver.
// - Overflow interrupt can wake idle processor.
// - Status write loads counter; sts_ovf_clear clears flag.
// - Alternating strobe writes give half-rate master.
// - Wire mode 01 overrides data port bit.
// - Software strobe shifts and counts, output immediate.
module usw_three_wire
  import usw_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              link_sck,
  input  wire logic              serial_data_in,
  // Control write
  input  wire logic              ctl_wr,
  input  wire logic [WM_W-1:0]   ctl_wire_mode,
  input  wire logic              ctl_external_clock_select,
  input  wire logic              ctl_clock_edge_select,
  input  wire logic              ctl_clock_strobe,
  input  wire logic              ctl_toggle_strobe,
  // Status write
  input  wire logic              sts_wr,
  input  wire logic              sts_ovf_clear,
  input  wire logic [CNT_W-1:0]  sts_count,
  // Data and port writes
  input  wire logic              dat_wr,
  input  wire logic [DR_W-1:0]   dat_wdata,
  input  wire logic              port_wr,
  input  wire logic              port_clock_bit,
  input  wire logic              clock_pin_direction,
  input  wire logic              port_data_bit,
  input  wire logic              data_pin_direction,
  // Timer clock and interrupt gate
  input  wire logic              timer_ovf,
  input  wire logic              ovf_int_enable,
  // Readback
  output logic [RD_W-1:0]        ctl_rdata,
  output logic [DR_W-1:0]        serial_data_register,
  output logic [CNT_W-1:0]       counter_value,
  output logic                   ovf_flag,
  output logic                   ovf_irq,
  // Pins
  output logic                   clock_port_bit,
  output logic                   clock_port_pin_o,
  output logic                   clock_port_pin_oe,
  output logic                   data_pin_o,
  output logic                   data_pin_oe
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    usw_ctl_t          ctl;
    logic [DR_W-1:0]   dr;
    logic              do_latch;
    logic [CNT_W-1:0]  cnt;
    logic              ovf;
    logic              port_bit;
    // Crossing stages
    logic [SYNC_N-1:0] rt_sy;
    logic [SYNC_N-1:0] ft_sy;
    logic [SYNC_N-1:0] rb_sy;
    logic [SYNC_N-1:0] fb_sy;
    logic [SYNC_N-1:0] di_sy;
    // Last accepted levels
    logic              rise_seen;
    logic              fall_seen;
    logic              di_lvl;
  } usw_main_st_t;

  localparam usw_main_st_t ST_RST = '{
    CTL_RST,
    DR_RST,
    1'b0,
    CNT_RST,
    1'b0,
    1'b0,
    '0,
    '0,
    '0,
    '0,
    '0,
    1'b0,
    1'b0,
    1'b0
  };

  usw_main_st_t st_r;
  usw_main_st_t st_nxt;

  usw_link_if u_link_if ();

  // ****************************************
  // Link clock domain
  // ****************************************
  usw_link_edge u_link_edge (
    .link_sck       (link_sck),
    .rst            (rst),
    .serial_data_in (serial_data_in),
    .lk             (u_link_if)
  );

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [DR_W-1:0] shift_in(
    input logic [DR_W-1:0] cur,
    input logic            in_bit
  );
    shift_in = {cur[DR_MSB-1:DR_LSB], in_bit};
  endfunction

  function automatic logic [SYNC_N-1:0] sync_step(
    input logic [SYNC_N-1:0] cur,
    input logic              raw
  );
    sync_step = {cur[SY_MID], cur[SY_NEW], raw};
  endfunction

  function automatic logic agreed(input logic [SYNC_N-1:0] cur);
    agreed = (cur[SY_MID] == cur[SY_OLD]);
  endfunction

  function automatic logic new_event(
    input logic [SYNC_N-1:0] cur,
    input logic              seen
  );
    new_event = agreed(cur) && (cur[SY_OLD] != seen);
  endfunction

  function automatic logic pick_edge(
    input logic falling,
    input logic on_rise,
    input logic on_fall
  );
    pick_edge = falling ? on_fall : on_rise;
  endfunction

  function automatic logic [1:0] edge_count(
    input logic on_rise,
    input logic on_fall
  );
    edge_count = INC_NONE;
    if (on_rise && on_fall) begin
      edge_count = INC_TWO;
    end else if (on_rise || on_fall) begin
      edge_count = INC_ONE;
    end
  endfunction

  function automatic logic [RD_W-1:0] ctl_readback(input usw_ctl_t c);
    ctl_readback                    = '0;
    ctl_readback[RD_WM_HI:RD_WM_LO] = c.wire_mode;
    ctl_readback[RD_ECS]            = c.external_clock_select;
    ctl_readback[RD_CES]            = c.clock_edge_select;
    ctl_readback[RD_STROBE]         = c.external_clock_select && c.clock_strobe_sel;
    ctl_readback[RD_TOGGLE]         = 1'b0;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  usw_ctl_t         mode;
  logic             rise_ev;
  logic             fall_ev;
  logic             sample_ev;
  logic             launch_ev;
  logic             sample_bit;
  logic             sw_strobe;
  logic             toggle_cnt;
  logic [1:0]       inc_amt;
  logic [CNT_W:0]   cnt_sum;
  logic             wrap;

  always_comb begin
    st_nxt = st_r;

    // ****************************************
    // Crossings from the link domain and the data pin
    // ****************************************
    st_nxt.rt_sy = sync_step(st_r.rt_sy, u_link_if.rise_tgl);
    st_nxt.ft_sy = sync_step(st_r.ft_sy, u_link_if.fall_tgl);
    st_nxt.rb_sy = sync_step(st_r.rb_sy, u_link_if.rise_bit);
    st_nxt.fb_sy = sync_step(st_r.fb_sy, u_link_if.fall_bit);
    st_nxt.di_sy = sync_step(st_r.di_sy, serial_data_in);

    rise_ev = new_event(st_r.rt_sy, st_r.rise_seen);
    fall_ev = new_event(st_r.ft_sy, st_r.fall_seen);
    if (agreed(st_r.rt_sy)) begin
      st_nxt.rise_seen = st_r.rt_sy[SY_OLD];
    end
    if (agreed(st_r.ft_sy)) begin
      st_nxt.fall_seen = st_r.ft_sy[SY_OLD];
    end
    if (agreed(st_r.di_sy)) begin
      st_nxt.di_lvl = st_r.di_sy[SY_OLD];
    end

    // ****************************************
    // Settings of a control write act in the same cycle
    // ****************************************
    mode = st_r.ctl;
    if (ctl_wr) begin
      mode.wire_mode             = ctl_wire_mode;
      mode.external_clock_select = ctl_external_clock_select;
      mode.clock_edge_select     = ctl_clock_edge_select;
      mode.clock_strobe_sel      = ctl_clock_strobe;
      st_nxt.ctl                 = mode;
    end

    // ****************************************
    // Clock port bit and toggle strobe
    // ****************************************
    if (port_wr) begin
      st_nxt.port_bit = port_clock_bit;
    end
    if (ctl_wr && ctl_toggle_strobe) begin
      st_nxt.port_bit = ~st_nxt.port_bit;
    end

    // ****************************************
    // Edge choice for external clocking
    // ****************************************
    sample_ev  = pick_edge(mode.clock_edge_select, rise_ev, fall_ev);
    launch_ev  = pick_edge(mode.clock_edge_select, fall_ev, rise_ev);
    sample_bit = pick_edge(mode.clock_edge_select, st_r.rb_sy[SY_OLD], st_r.fb_sy[SY_OLD]);

    // ****************************************
    // Software strobe or timer overflow clocks shift and counter
    // ****************************************
    sw_strobe = 1'b0;
    if (!mode.external_clock_select) begin
      if (!mode.clock_edge_select) begin
        sw_strobe = ctl_wr && ctl_clock_strobe;
      end else begin
        sw_strobe = timer_ovf;
      end
    end

    toggle_cnt = mode.external_clock_select && mode.clock_strobe_sel && ctl_wr && ctl_toggle_strobe;

    // ****************************************
    // Shift register
    // ****************************************
    if (dat_wr) begin
      st_nxt.dr       = dat_wdata;
      st_nxt.do_latch = dat_wdata[DR_MSB];
    end else if (sw_strobe) begin
      st_nxt.dr = shift_in(st_r.dr, st_r.di_lvl);
    end else if (mode.external_clock_select && sample_ev) begin
      st_nxt.dr = shift_in(st_r.dr, sample_bit);
    end
    if (!dat_wr && mode.external_clock_select && launch_ev) begin
      st_nxt.do_latch = st_r.dr[DR_MSB];
    end

    // ****************************************
    // Counter increment amount
    // ****************************************
    inc_amt = INC_NONE;
    if (sw_strobe || toggle_cnt) begin
      inc_amt = INC_ONE;
    end else if (mode.external_clock_select && !mode.clock_strobe_sel) begin
      inc_amt = edge_count(rise_ev, fall_ev);
    end

    cnt_sum = {1'b0, st_r.cnt} + {3'h0, inc_amt};
    wrap    = cnt_sum[CNT_W];
    st_nxt.cnt = cnt_sum[CNT_W-1:0];

    // ****************************************
    // Status write loads the counter and may clear the flag
    // ****************************************
    if (sts_wr) begin
      st_nxt.cnt = sts_count;
      if (sts_ovf_clear) begin
        st_nxt.ovf = 1'b0;
      end
    end
    if (wrap) begin
      st_nxt.ovf = 1'b1;
    end

    if (rst) begin
      st_nxt = ST_RST;
    end
  end

  // ****************************************
  // Registers
  // ****************************************

  always_ff @(posedge mclk) begin
    st_r <= st_nxt;
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic three_wire;
  logic do_bit;

  assign three_wire = (st_r.ctl.wire_mode == WM_THREE_WIRE);
  assign do_bit     = st_r.ctl.external_clock_select ? st_r.do_latch : st_r.dr[DR_MSB];

  // ****************************************
  // Pin drive
  // ****************************************

  assign data_pin_o        = three_wire ? do_bit : port_data_bit;
  assign data_pin_oe       = data_pin_direction;
  assign clock_port_bit    = st_r.port_bit;
  assign clock_port_pin_o  = st_r.port_bit;
  assign clock_port_pin_oe = clock_pin_direction;

  // ****************************************
  // Register views
  // ****************************************

  assign serial_data_register = st_r.dr;
  assign counter_value        = st_r.cnt;
  assign ovf_flag             = st_r.ovf;
  assign ovf_irq              = st_r.ovf && ovf_int_enable;

  // ****************************************
  // Control readback
  // ****************************************

  always_comb begin
    ctl_rdata = ctl_readback(st_r.ctl);
  end

endmodule

// ===== usw_chk.sv
`timescale 1ns/1ps
module usw_chk
  import usw_pkg::*;
(
  input wire logic             mclk,
  input wire logic             rst,
  input wire logic             ctl_wr,
  input wire logic             ctl_external_clock_select,
  input wire logic             ctl_clock_edge_select,
  input wire logic             ctl_clock_strobe,
  input wire logic             ctl_toggle_strobe,
  input wire logic             sts_wr,
  input wire logic             sts_ovf_clear,
  input wire logic [CNT_W-1:0] sts_count,
  input wire logic             dat_wr,
  input wire logic [DR_W-1:0]  dat_wdata,
  input wire logic             port_wr,
  input wire logic [RD_W-1:0]  ctl_rdata,
  input wire logic [DR_W-1:0]  serial_data_register,
  input wire logic [CNT_W-1:0] counter_value,
  input wire logic             ovf_flag,
  input wire logic             clock_port_bit
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_tgl;
    ctl_wr && ctl_toggle_strobe && !port_wr |=> clock_port_bit != $past(clock_port_bit);
  endproperty
  a_tgl: assert property (p_tgl) else $error("toggle lost");
  property p_rdz;
    ctl_wr |=> (ctl_rdata[RD_TOGGLE] == 1'b0) [*2];
  endproperty
  a_rdz: assert property (p_rdz) else $error("toggle reads one");
  property p_tcnt;
    ctl_wr && ctl_external_clock_select && ctl_clock_strobe && ctl_toggle_strobe && !sts_wr
      |=> counter_value == $past(counter_value) + 4'h1;
  endproperty
  a_tcnt: assert property (p_tcnt) else $error("toggle count");
  property p_sw;
    ctl_wr && !ctl_external_clock_select && !ctl_clock_edge_select && ctl_clock_strobe && !sts_wr && !dat_wr
      |=> counter_value == $past(counter_value) + 4'h1 && serial_data_register[7:1] == $past(serial_data_register[6:0]);
  endproperty
  a_sw: assert property (p_sw) else $error("strobe shift");
  property p_sts;
    sts_wr && sts_ovf_clear && !ctl_wr |=> counter_value == $past(sts_count) && !ovf_flag;
  endproperty
  a_sts: assert property (p_sts) else $error("status write");
  property p_stk;
    ovf_flag && !sts_wr |=> ovf_flag;
  endproperty
  a_stk: assert property (p_stk) else $error("flag dropped");
  property p_wrap;
    counter_value == CNT_MAX && !sts_wr ##1 counter_value == CNT_RST |-> ovf_flag;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no overflow");
  property p_dat;
    dat_wr |=> serial_data_register == $past(dat_wdata);
  endproperty
  a_dat: assert property (p_dat) else $error("data write");
  c_ovf: cover property ($rose(ovf_flag));
  c_tcnt: cover property (ctl_wr && ctl_toggle_strobe && ctl_clock_strobe);
  c_sw: cover property (ctl_wr && ctl_clock_strobe && !ctl_external_clock_select);
endmodule

bind usw_three_wire usw_chk usw_chk_inst (
  .mclk(mclk), .rst(rst), .ctl_wr(ctl_wr), .ctl_external_clock_select(ctl_external_clock_select),
  .ctl_clock_edge_select(ctl_clock_edge_select), .ctl_clock_strobe(ctl_clock_strobe),
  .ctl_toggle_strobe(ctl_toggle_strobe), .sts_wr(sts_wr), .sts_ovf_clear(sts_ovf_clear),
  .sts_count(sts_count), .dat_wr(dat_wr), .dat_wdata(dat_wdata), .port_wr(port_wr), .ctl_rdata(ctl_rdata),
  .serial_data_register(serial_data_register), .counter_value(counter_value), .ovf_flag(ovf_flag),
  .clock_port_bit(clock_port_bit)
);

// ===== usw_far_master.sv
`timescale 1ns/1ps
module usw_far_master (
  output logic     link_sck,
  output logic     serial_data_in,
  input wire logic data_pin_o
);
  logic [7:0] rx_r;
  initial begin
    link_sck = 1'b0;
    serial_data_in = 1'b1;
    rx_r = 8'h00;
  end
  // One byte MSB first, half period 6*k ns, clock idles low
  task automatic xfer(input logic [7:0] tx, input logic mode, input int k);
    for (int i = 7; i >= 0; i--) begin
      if (!mode) serial_data_in = tx[i];
      #(6 * k) link_sck = 1'b1;
      if (mode) serial_data_in = tx[i];
      else rx_r = {rx_r[6:0], data_pin_o};
      #(6 * k) link_sck = 1'b0;
      if (mode) rx_r = {rx_r[6:0], data_pin_o};
    end
    #(6 * k) serial_data_in = ~serial_data_in;
  endtask
endmodule

// ===== tb_universal_serial_three_wire.sv
`timescale 1ns/1ps
module tb_universal_serial_three_wire;
  import usw_pkg::*;
  logic             mclk, rst, link_sck, serial_data_in, ctl_wr, ctl_external_clock_select;
  logic             ctl_clock_edge_select, ctl_clock_strobe, ctl_toggle_strobe, sts_wr, sts_ovf_clear;
  logic             dat_wr, port_wr, port_clock_bit, clock_pin_direction, port_data_bit, data_pin_direction;
  logic             timer_ovf, ovf_int_enable, ovf_flag, ovf_irq, clock_port_bit, clock_port_pin_o;
  logic             clock_port_pin_oe, data_pin_o, data_pin_oe, d, p;
  logic [WM_W-1:0]  ctl_wire_mode;
  logic [CNT_W-1:0] sts_count, counter_value, c;
  logic [DR_W-1:0]  dat_wdata, serial_data_register, b, r, e_m, o_m;
  logic [RD_W-1:0]  ctl_rdata;
  int               num_errors, checks_done, cyc, k_m;
  int               knd_q[$];
  logic [7:0]       exp_q[$];
  event             look;

  usw_three_wire usw_three_wire_inst (.*);
  usw_far_master usw_far_master_inst (.*);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // ****
  // Expectation queue and monitor
  // ****
  task automatic note(input int k, input logic [7:0] v);
    knd_q.push_back(k);
    exp_q.push_back(v);
    ->look;
  endtask
  always @(look) begin
    while (exp_q.size() > 0) begin
      k_m = knd_q.pop_front();
      e_m = exp_q.pop_front();
      case (k_m)
        0: o_m = serial_data_register;
        1: o_m = {4'h0, counter_value};
        2: o_m = {7'h00, ovf_flag};
        3: o_m = {7'h00, clock_port_bit};
        4: o_m = ctl_rdata;
        6: o_m = {4'h0, ovf_irq, clock_port_pin_oe, data_pin_oe, clock_port_pin_o};
        default: o_m = usw_far_master_inst.rx_r;
      endcase
      checks_done++;
      if (o_m !== e_m) begin
        num_errors++;
        $display("[ERR] t=%0t got %h exp %h", $time, o_m, e_m);
      end
    end
  end
  task automatic ctl(input logic e, g, s, t);
    ctl_wr = 1'b1;
    ctl_wire_mode = WM_THREE_WIRE;
    {ctl_external_clock_select, ctl_clock_edge_select, ctl_clock_strobe, ctl_toggle_strobe} = {e, g, s, t};
    @(negedge mclk);
  endtask
  task automatic cend;
    ctl_wr = 1'b0;
    @(negedge mclk);
  endtask
  task automatic sts(input logic [3:0] v);
    {sts_wr, sts_ovf_clear, sts_count} = {2'b11, v};
    @(negedge mclk);
    sts_wr = 1'b0;
    @(negedge mclk);
  endtask
  task automatic dat(input logic [7:0] v);
    {dat_wr, dat_wdata} = {1'b1, v};
    @(negedge mclk);
    dat_wr = 1'b0;
    @(negedge mclk);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      end_of_test;
    end
  end
  initial begin
    rst = 1'b1;
    {ctl_wr, ctl_wire_mode, ctl_external_clock_select, ctl_clock_edge_select, ctl_clock_strobe} = '0;
    {ctl_toggle_strobe, sts_wr, sts_ovf_clear, sts_count, dat_wr, dat_wdata, port_wr} = '0;
    {port_clock_bit, clock_pin_direction, port_data_bit, timer_ovf} = '0;
    {data_pin_direction, ovf_int_enable} = 2'b11;
    void'($urandom(32'hebe57d8b));
    fork
      #3 usw_far_master_inst.xfer(8'h00, 1'b0, 1);
    join_none
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    note(1, 8'h00);
    note(2, 8'h00);
    note(4, 8'h00);
    $display("reset test done");
    b = $urandom();
    d = usw_far_master_inst.serial_data_in;
    sts(4'h0);
    dat(b);
    note(0, b);
    for (int i = 1; i <= 8; i++) begin
      ctl(1'b0, 1'b0, 1'b1, 1'b0);
      cend;
      note(0, 8'({b, {8{d}}} >> (8 - i)));
      note(1, 8'(i));
    end
    $display("strobe test done");
    {port_wr, port_clock_bit, clock_pin_direction} = {1'b1, 2'($urandom())};
    p = port_clock_bit;
    @(negedge mclk);
    port_wr = 1'b0;
    note(3, {7'h00, p});
    ctl(1'b0, 1'b0, 1'b0, 1'b1);
    cend;
    note(3, {7'h00, ~p});
    note(4, 8'h10);
    sts(4'h0);
    for (int i = 0; i < 16; i++) ctl(1'b1, 1'b0, i[0], 1'b1);
    cend;
    note(1, 8'h08);
    note(3, {7'h00, ~p});
    note(4, 8'h1a);
    $display("toggle test done");
    sts(4'h0);
    repeat (16) ctl(1'b1, 1'b0, 1'b1, 1'b1);
    cend;
    note(1, 8'h00);
    note(2, 8'h01);
    note(6, {4'h0, 1'b1, clock_pin_direction, 1'b1, ~p});
    repeat (5) @(negedge mclk);
    note(2, 8'h01);
    c = $urandom();
    sts(c);
    note(1, {4'h0, c});
    note(2, 8'h00);
    note(6, {4'h0, 1'b0, clock_pin_direction, 1'b1, ~p});
    $display("master test done");
    for (int m = 0; m < 2; m++) begin
      b = $urandom();
      r = $urandom();
      sts(4'h0);
      dat(b);
      ctl(1'b1, m[0], 1'b0, 1'b0);
      cend;
      usw_far_master_inst.xfer(r, m[0], 20 + 10 * m);
      repeat (8) @(negedge mclk);
      note(0, r);
      note(1, 8'h00);
      note(2, 8'h01);
      note(5, b);
    end
    $display("link test done");
    @(negedge mclk);
    end_of_test;
  end
endmodule
